// ===== rtl/alarm_regs_pkg.sv
// constants, types and register map for the loop 5 / monitor alarm bank
package alarm_regs_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_TUNE = 8'h6F;
    localparam logic [7:0] IDX_SP_HI = 8'h70;
    localparam logic [7:0] IDX_SP_LO = 8'h71;
    localparam logic [7:0] IDX_L5_KIND = 8'h72;
    localparam logic [7:0] IDX_L5_MODE = 8'h73;
    localparam logic [7:0] IDX_L5_OSEL = 8'h74;
    localparam logic [7:0] IDX_L5_AHI = 8'h75;
    localparam logic [7:0] IDX_L5_ALO = 8'h76;
    localparam logic [7:0] IDX_L5_HYS = 8'h77;
    localparam logic [7:0] IDX_M1_PV = 8'h78;
    localparam logic [7:0] IDX_M1_KIND = 8'h79;
    localparam logic [7:0] IDX_M1_MODE = 8'h7A;
    localparam logic [7:0] IDX_M1_OSEL = 8'h7B;
    localparam logic [7:0] IDX_M1_AHI = 8'h7C;
    localparam logic [7:0] IDX_M1_ALO = 8'h7D;
    localparam logic [7:0] IDX_M1_HYS = 8'h7E;
    localparam logic [7:0] IDX_M2_PV = 8'h7F;
    localparam logic [7:0] IDX_M2_KIND = 8'h80;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
    localparam logic [7:0] IDX_ALM_STAT = 8'h92;
    // autotune codes
    localparam logic [15:0] TUNE_OFF = 16'h0000;
    localparam logic [15:0] TUNE_START = 16'h0001;
    localparam logic [15:0] TUNE_ACTIVE = 16'h0002;
    localparam logic [15:0] TUNE_STOP = 16'h0004;
    // alarm kinds
    localparam logic [15:0] KIND_OFF = 16'h0000;
    localparam logic [15:0] KIND_PHI = 16'h0001;
    localparam logic [15:0] KIND_PLO = 16'h0002;
    localparam logic [15:0] KIND_PBOTH = 16'h0003;
    localparam logic [15:0] KIND_DHI = 16'h0004;
    localparam logic [15:0] KIND_DLO = 16'h0005;
    localparam logic [15:0] KIND_DBOTH = 16'h0006;
    // mode bit positions
    localparam int MODE_LATCH = 1;
    localparam int MODE_OPEN = 2;
    localparam int MODE_AUDIBLE = 5;
    localparam int MODE_SHUTDOWN = 6;
    localparam logic [15:0] HYS_MAX = 16'h7FFF;
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam logic [2:0] IRQ_W = 3'h0;
    localparam int NCH = 3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [15:0] kind;
        logic [15:0] mode;
        logic [15:0] osel;
        logic [15:0] ahi;
        logic [15:0] alo;
        logic [15:0] hys;
    } alarm_cfg_t;
endpackage

// ===== rtl/loop_and_monitor_alarm_regs.sv
// register bank and alarm evaluation for loop 5 and monitor channels 1, 2
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - autotune register codes: 0 off, 1 start, 2 active, 4 stop
// - setpoint ceiling and floor hold any signed 16-bit tenths value
// - loop 5 alarm kind: off, process and deviation high/low/both
// - monitor alarm kinds: off and process high/low/both only
// - mode bit 1 clear self-clears, set latches the alarm
// - mode bit 2 clear closes output on alarm, set opens it
// - mode bit 5 enables the audible indication
// - mode bit 6 shuts the chamber down on alarm
// - all other mode bits are ignored
// - output select is a bit mask: zero none, each set bit n event output n+1
// - loop 5 alarm thresholds are signed 16-bit read/write values
// - hysteresis registers accept only 0 to 32767
// - monitor 1 process value is read-only signed 16-bit
// - monitor 2 process value is read-only signed 16-bit
// - monitor 1 alarm thresholds are signed read/write values
module loop_and_monitor_alarm_regs (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic [15:0] LOOP5_SETPOINT_IN,
    input wire logic [15:0] LOOP5_PROCESS_IN,
    input wire logic [15:0] MON1_PROCESS_IN,
    input wire logic [15:0] MON2_PROCESS_IN,
    input wire logic TUNE_ACTIVE_IN,
    input wire logic TUNE_DONE_IN,
    input wire logic ALARM_ACK_IN,
    output logic TUNE_START_OUT,
    output logic TUNE_STOP_OUT,
    output logic [14:0] EVENT_OUT,
    output logic AUDIBLE_OUT,
    output logic SHUTDOWN_OUT,
    output logic IRQ_OUT
);
    alarm_regs_pkg::alarm_cfg_t cfg_r [alarm_regs_pkg::NCH];
    alarm_regs_pkg::alarm_cfg_t cfg_nxt [alarm_regs_pkg::NCH];
    logic [15:0] tune_r, tune_nxt, sphi_r, sphi_nxt, splo_r, splo_nxt;
    logic [15:0] pv1_r, pv1_nxt, pv2_r, pv2_nxt;
    logic [2:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic [2:0] alm_r, alm_nxt;
    logic [2:0] alm_evt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] widx_r, widx_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [15:0] pv [alarm_regs_pkg::NCH];
    logic [15:0] wd;
    logic [7:0] aidx;
    logic take;
    logic mapped;
    logic [2:0] ack_sync_r, ack_sync_nxt;
    logic ack_r, ack_nxt;

    assign wd = HWDATA_IN[15:0];
    assign aidx = HADDR_IN[9:2];
    assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign pv[0] = LOOP5_PROCESS_IN;
    assign pv[1] = pv1_r;
    assign pv[2] = pv2_r;

    // acknowledge comes from an operator pin; it counts only once the
    // second and third stages agree, so a glitch cannot unlatch an alarm
    always_comb begin
        ack_sync_nxt = {ack_sync_r[1:0], ALARM_ACK_IN};
        ack_nxt = ack_r;
        if (ack_sync_r[1] == ack_sync_r[2]) begin
            ack_nxt = ack_sync_r[2];
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ack_sync_r <= 3'h0;
            ack_r <= 1'b0;
        end else begin
            ack_sync_r <= ack_sync_nxt;
            ack_r <= ack_nxt;
        end
    end

    // index 0 is loop 5, 1 and 2 are the monitors
    function automatic logic [7:0] cfg_idx(input int ch, input int fld);
        logic [7:0] base;
        base = (ch == 0) ? alarm_regs_pkg::IDX_L5_KIND :
               (ch == 1) ? alarm_regs_pkg::IDX_M1_KIND :
               alarm_regs_pkg::IDX_M2_KIND;
        cfg_idx = base + 8'(fld);
    endfunction

    // monitor 2 has only its kind register in this bank
    function automatic logic fld_ok(input int ch, input int fld);
        fld_ok = (ch != 2) || (fld == 0);
    endfunction

    // writes that are not a defined kind are ignored
    function automatic logic kind_ok(input int ch, input logic [15:0] v);
        if (ch == 0) begin
            kind_ok = (v <= alarm_regs_pkg::KIND_DBOTH);
        end else begin
            kind_ok = (v <= alarm_regs_pkg::KIND_PBOTH);
        end
    endfunction

    always_comb begin
        mapped = 1'b0;
        rdata_nxt = rdata_r;
        case (aidx)
            alarm_regs_pkg::IDX_TUNE,
            alarm_regs_pkg::IDX_SP_HI,
            alarm_regs_pkg::IDX_SP_LO,
            alarm_regs_pkg::IDX_M1_PV,
            alarm_regs_pkg::IDX_M2_PV,
            alarm_regs_pkg::IDX_IRQ_STAT,
            alarm_regs_pkg::IDX_IRQ_MASK,
            alarm_regs_pkg::IDX_ALM_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        for (int c = 0; c < alarm_regs_pkg::NCH; c++) begin
            for (int f = 0; f < 6; f++) begin
                if (fld_ok(c, f) && aidx == cfg_idx(c, f)) begin
                    mapped = 1'b1;
                end
            end
        end
        if (take && !HWRITE_IN) begin
            rdata_nxt = 32'h0000_0000;
            case (aidx)
                alarm_regs_pkg::IDX_TUNE: rdata_nxt[15:0] = tune_r;
                alarm_regs_pkg::IDX_SP_HI: rdata_nxt[15:0] = sphi_r;
                alarm_regs_pkg::IDX_SP_LO: rdata_nxt[15:0] = splo_r;
                alarm_regs_pkg::IDX_M1_PV: rdata_nxt[15:0] = pv1_r;
                alarm_regs_pkg::IDX_M2_PV: rdata_nxt[15:0] = pv2_r;
                alarm_regs_pkg::IDX_IRQ_STAT: rdata_nxt[2:0] = irq_stat_r;
                alarm_regs_pkg::IDX_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
                alarm_regs_pkg::IDX_ALM_STAT: rdata_nxt[2:0] = alm_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
            for (int c = 0; c < alarm_regs_pkg::NCH; c++) begin
                for (int f = 0; f < 6; f++) begin
                    if (fld_ok(c, f) && aidx == cfg_idx(c, f)) begin
                        rdata_nxt[15:0] = cfg_r[c][(5 - f) * 16 +: 16];
                    end
                end
            end
        end
    end

    assign wr_pend_nxt = take && HWRITE_IN && mapped;
    assign widx_nxt = take ? aidx : widx_r;

    // register writes in the data phase, hardware updates alongside
    always_comb begin
        tune_nxt = tune_r;
        sphi_nxt = sphi_r;
        splo_nxt = splo_r;
        irq_mask_nxt = irq_mask_r;
        cfg_nxt = cfg_r;
        pv1_nxt = MON1_PROCESS_IN;
        pv2_nxt = MON2_PROCESS_IN;
        // autotune handshake with the loop; host write wins
        if (tune_r == alarm_regs_pkg::TUNE_START && TUNE_ACTIVE_IN) begin
            tune_nxt = alarm_regs_pkg::TUNE_ACTIVE;
        end else if (TUNE_DONE_IN) begin
            tune_nxt = alarm_regs_pkg::TUNE_OFF;
        end
        if (wr_pend_r) begin
            case (widx_r)
                alarm_regs_pkg::IDX_TUNE: begin
                    if (wd == alarm_regs_pkg::TUNE_OFF ||
                        wd == alarm_regs_pkg::TUNE_START ||
                        wd == alarm_regs_pkg::TUNE_STOP) begin
                        tune_nxt = wd;
                    end
                end
                alarm_regs_pkg::IDX_SP_HI: sphi_nxt = wd;
                alarm_regs_pkg::IDX_SP_LO: splo_nxt = wd;
                alarm_regs_pkg::IDX_IRQ_MASK: irq_mask_nxt = wd[2:0];
                default: tune_nxt = tune_nxt;
            endcase
            for (int c = 0; c < alarm_regs_pkg::NCH; c++) begin
                for (int f = 0; f < 6; f++) begin
                    if (fld_ok(c, f) && widx_r == cfg_idx(c, f)) begin
                        if (f == 0) begin
                            if (kind_ok(c, wd)) begin
                                cfg_nxt[c].kind = wd;
                            end
                        end else if (f == 5) begin
                            if (wd <= alarm_regs_pkg::HYS_MAX) begin
                                cfg_nxt[c].hys = wd;
                            end
                        end else begin
                            cfg_nxt[c][(5 - f) * 16 +: 16] = wd;
                        end
                    end
                end
            end
        end
    end

    // per-channel alarm evaluation
    for (genvar g = 0; g < alarm_regs_pkg::NCH; g++) begin : g_alm
        logic signed [17:0] v, hi, lo, h, dev;
        logic over, under, rel_hi, rel_lo, want_hi, want_lo, cond, rel;
        always_comb begin
            v = 18'(signed'(pv[g]));
            h = 18'(cfg_r[g].hys);
            dev = 18'(signed'(LOOP5_SETPOINT_IN));
            hi = 18'(signed'(cfg_r[g].ahi));
            lo = 18'(signed'(cfg_r[g].alo));
            // deviation thresholds are relative to the setpoint
            if (cfg_r[g].kind >= alarm_regs_pkg::KIND_DHI) begin
                hi = dev + hi;
                lo = dev - lo;
            end
            want_hi = cfg_r[g].kind == alarm_regs_pkg::KIND_PHI ||
                      cfg_r[g].kind == alarm_regs_pkg::KIND_PBOTH ||
                      cfg_r[g].kind == alarm_regs_pkg::KIND_DHI ||
                      cfg_r[g].kind == alarm_regs_pkg::KIND_DBOTH;
            want_lo = cfg_r[g].kind == alarm_regs_pkg::KIND_PLO ||
                      cfg_r[g].kind == alarm_regs_pkg::KIND_PBOTH ||
                      cfg_r[g].kind == alarm_regs_pkg::KIND_DLO ||
                      cfg_r[g].kind == alarm_regs_pkg::KIND_DBOTH;
            over = want_hi && v > hi;
            under = want_lo && v < lo;
            rel_hi = !want_hi || v <= hi - h;
            rel_lo = !want_lo || v >= lo + h;
            cond = over || under;
            rel = rel_hi && rel_lo;
            alm_nxt[g] = alm_r[g];
            if (cond) begin
                alm_nxt[g] = 1'b1;
            end else if (rel && (!cfg_r[g].mode[alarm_regs_pkg::MODE_LATCH]
                                 || ack_r)) begin
                alm_nxt[g] = 1'b0;
            end
            alm_evt[g] = cond && !alm_r[g];
        end
    end

    // sticky status, set beats a write-one clear
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_pend_r && widx_r == alarm_regs_pkg::IDX_IRQ_STAT) begin
            irq_stat_nxt = irq_stat_r & ~wd[2:0];
        end
        irq_stat_nxt = irq_stat_nxt | alm_evt;
    end

    // only bits 1, 2, 5 and 6 of a mode word are ever looked at
    always_comb begin
        EVENT_OUT = 15'h0000;
        AUDIBLE_OUT = 1'b0;
        SHUTDOWN_OUT = 1'b0;
        for (int c = 0; c < alarm_regs_pkg::NCH; c++) begin
            // relay closed when active xor open-on-alarm
            if (alm_r[c] != cfg_r[c].mode[alarm_regs_pkg::MODE_OPEN]) begin
                EVENT_OUT = EVENT_OUT | cfg_r[c].osel[14:0];
            end
            if (alm_r[c] && cfg_r[c].mode[alarm_regs_pkg::MODE_AUDIBLE]) begin
                AUDIBLE_OUT = 1'b1;
            end
            if (alm_r[c] && cfg_r[c].mode[alarm_regs_pkg::MODE_SHUTDOWN]) begin
                SHUTDOWN_OUT = 1'b1;
            end
        end
    end

    assign TUNE_START_OUT = (tune_r == alarm_regs_pkg::TUNE_START);
    assign TUNE_STOP_OUT = (tune_r == alarm_regs_pkg::TUNE_STOP);
    assign IRQ_OUT = |(irq_stat_r & irq_mask_r);
    assign HRDATA_OUT = rdata_r;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    // bus pipeline state for the data phase
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            wr_pend_r <= 1'b0;
            widx_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            widx_r <= widx_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // settings and process values; a read of a process value is
    // always one cycle old, the price of a plain sampling stage
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            for (int c = 0; c < alarm_regs_pkg::NCH; c++) begin
                cfg_r[c] <= '0;
            end
            tune_r <= alarm_regs_pkg::TUNE_OFF;
            sphi_r <= alarm_regs_pkg::RESET_ZERO;
            splo_r <= alarm_regs_pkg::RESET_ZERO;
            pv1_r <= alarm_regs_pkg::RESET_ZERO;
            pv2_r <= alarm_regs_pkg::RESET_ZERO;
            irq_mask_r <= alarm_regs_pkg::IRQ_W;
        end else begin
            cfg_r <= cfg_nxt;
            tune_r <= tune_nxt;
            sphi_r <= sphi_nxt;
            splo_r <= splo_nxt;
            pv1_r <= pv1_nxt;
            pv2_r <= pv2_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // live alarm state, one bit per channel; it drops only through
    // the release test of the evaluation above
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            alm_r <= alarm_regs_pkg::IRQ_W;
        end else begin
            alm_r <= alm_nxt;
        end
    end

    // sticky interrupt status
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            irq_stat_r <= alarm_regs_pkg::IRQ_W;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end
endmodule // loop_and_monitor_alarm_regs

// ===== tb/alarm_regs_checker.sv
// concurrent checks on the ports of the alarm register bank
`timescale 1ns/1ps
module alarm_regs_checker (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic [15:0] MON1_PROCESS_IN,
    input wire logic TUNE_ACTIVE_IN,
    input wire logic TUNE_DONE_IN,
    input wire logic TUNE_START_OUT,
    input wire logic TUNE_STOP_OUT,
    input wire logic [14:0] EVENT_OUT,
    input wire logic AUDIBLE_OUT,
    input wire logic SHUTDOWN_OUT,
    input wire logic IRQ_OUT
);
    logic wr_d_r;
    logic wr_d_nxt;
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    sequence s_take;
        HSEL_IN && HREADY_IN && HTRANS_IN[1];
    endsequence
    sequence s_pv1_read;
        s_take ##0 (!HWRITE_IN && $stable(MON1_PROCESS_IN)
            && HADDR_IN == {22'h0, alarm_regs_pkg::IDX_M1_PV, 2'b00});
    endsequence
    // a write in its data phase may overrule the status inputs
    always_comb wr_d_nxt = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN;
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) wr_d_r <= 1'b0;
        else wr_d_r <= wr_d_nxt;
    end
    chk_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
        else $error("bus answer not ready or not okay");
    chk_rdata_upper: assert property (HRDATA_OUT[31:16] == 16'h0000)
        else $error("upper read data not zero");
    chk_rdata_hold: assert property (
        !(HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN)
        |=> $stable(HRDATA_OUT))
        else $error("read data moved without a read");
    chk_pv1_read: assert property (
        s_pv1_read |=> HRDATA_OUT[15:0] == $past(MON1_PROCESS_IN))
        else $error("monitor value read back wrong");
    chk_tune_excl: assert property (
        !(TUNE_START_OUT && TUNE_STOP_OUT))
        else $error("start and stop requested together");
    chk_tune_done: assert property (
        TUNE_DONE_IN && !TUNE_ACTIVE_IN && !wr_d_r
        |=> !TUNE_START_OUT && !TUNE_STOP_OUT)
        else $error("autotune not back to off");
    chk_tune_advance: assert property (
        TUNE_START_OUT && TUNE_ACTIVE_IN && !wr_d_r |=> !TUNE_START_OUT)
        else $error("autotune start not left when active");
    chk_reset_quiet: assert property ($rose(NRST_IN) |-> EVENT_OUT == 15'h0
        && !AUDIBLE_OUT && !SHUTDOWN_OUT && !IRQ_OUT && !TUNE_START_OUT)
        else $error("outputs not quiet after reset");
endmodule // alarm_regs_checker

bind loop_and_monitor_alarm_regs alarm_regs_checker u_chk (
    .CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN), .HSEL_IN(HSEL_IN),
    .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .MON1_PROCESS_IN(MON1_PROCESS_IN), .TUNE_ACTIVE_IN(TUNE_ACTIVE_IN),
    .TUNE_DONE_IN(TUNE_DONE_IN), .TUNE_START_OUT(TUNE_START_OUT),
    .TUNE_STOP_OUT(TUNE_STOP_OUT), .EVENT_OUT(EVENT_OUT),
    .AUDIBLE_OUT(AUDIBLE_OUT), .SHUTDOWN_OUT(SHUTDOWN_OUT), .IRQ_OUT(IRQ_OUT));

// ===== tb/test_loop_and_monitor_alarm_regs.sv
// self-checking bench for the loop 5 and monitor alarm register bank
`timescale 1ns/1ps
`define CHECK_EQ(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t got %h expected %h", $time, (g), (e)); end end
module test_loop_and_monitor_alarm_regs;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, ack = 1'b0, t_act = 1'b0, t_done = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [15:0] proc5 = 16'h0, mon1 = 16'h1234, mon2 = 16'h0;
    logic hready, hresp, t_start, t_stop, audible, shutdown, irq;
    logic [14:0] events;
    logic [15:0] seed = 16'h0011, rd;
    logic [15:0] mdl [256] = '{default: 16'h0};
    int fails = 0, compares = 0;
    int vals [3] = '{100, -100, 60};
    always #20 clk = ~clk;
    loop_and_monitor_alarm_regs u_dut (.CORE_CLK_IN(clk), .NRST_IN(nrst),
        .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(alarm_regs_pkg::HSIZE_WORD),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .LOOP5_SETPOINT_IN(16'd20), .LOOP5_PROCESS_IN(proc5),
        .MON1_PROCESS_IN(mon1), .MON2_PROCESS_IN(mon2),
        .TUNE_ACTIVE_IN(t_act), .TUNE_DONE_IN(t_done), .ALARM_ACK_IN(ack),
        .TUNE_START_OUT(t_start), .TUNE_STOP_OUT(t_stop), .EVENT_OUT(events),
        .AUDIBLE_OUT(audible), .SHUTDOWN_OUT(shutdown), .IRQ_OUT(irq));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // refused writes leave the old value; unmapped places stay zero
    function automatic logic [15:0] acc(input logic [7:0] i,
        input logic [15:0] o, input logic [15:0] n);
        case (i)
            8'h6F: return (n == 0 || n == 1 || n == 4) ? n : o;
            8'h72: return (n <= 6) ? n : o;
            8'h79, 8'h80: return (n <= 3) ? n : o;
            8'h77, 8'h7E: return n[15] ? o : n;
            default: return (i >= 8'h70 && i <= 8'h7E && i != 8'h78) ? n : o;
        endcase
    endfunction
    // setpoint 20, high and low thresholds 50
    function automatic logic alarm_exp(input int k, input int v);
        case (k)
            1: return v > 50;
            2: return v < 50;
            3: return v > 50 || v < 50;
            4: return v > 70;
            5: return v < -30;
            6: return v > 70 || v < -30;
            default: return 1'b0;
        endcase
    endfunction
    task summarize;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wait_ready;
        int n;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (hready === 1'b1) break;
        end
        if (n == 64) begin
            fails++;
            summarize();
        end
    endtask
    task bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= alarm_regs_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        wait_ready();
        rd = hrdata[15:0];
        if (wr) mdl[idx] = acc(idx, mdl[idx], wd);
    endtask
    task rchk(input logic [7:0] idx);
        bus(1'b0, idx, 16'h0000);
        `CHECK_EQ(rd, idx == 8'h78 ? mon1 : idx == 8'h7F ? mon2 : mdl[idx])
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        mon2 <= 16'hBEEF;
        for (int i = 'h6E; i <= 'h81; i++) begin
            rchk(8'(i));
            repeat (2) begin
                seed = lfsr(seed);
                bus(1'b1, 8'(i), seed & (seed[0] ? 16'h0007 : 16'hFFFF));
                rchk(8'(i));
            end
        end
        // second reset in mid-run: every setting back to zero, process values resampled
        @(posedge clk) nrst <= 1'b0;
        @(posedge clk) nrst <= 1'b1;
        mdl = '{default: 16'h0};
        for (int i = 'h6F; i <= 'h80; i++) rchk(8'(i));
        bus(1'b1, alarm_regs_pkg::IDX_TUNE, alarm_regs_pkg::TUNE_START);
        settle(0);
        `CHECK_EQ(t_start, 1'b1)
        @(posedge clk) t_act <= 1'b1;
        @(posedge clk) t_act <= 1'b0;
        mdl[alarm_regs_pkg::IDX_TUNE] = alarm_regs_pkg::TUNE_ACTIVE;
        bus(1'b1, alarm_regs_pkg::IDX_TUNE, 16'h0003);
        rchk(alarm_regs_pkg::IDX_TUNE);
        bus(1'b1, alarm_regs_pkg::IDX_TUNE, alarm_regs_pkg::TUNE_STOP);
        settle(0);
        `CHECK_EQ({t_start, t_stop}, 2'b01)
        @(posedge clk) t_done <= 1'b1;
        @(posedge clk) t_done <= 1'b0;
        mdl[alarm_regs_pkg::IDX_TUNE] = alarm_regs_pkg::TUNE_OFF;
        rchk(alarm_regs_pkg::IDX_TUNE);
        @(posedge clk) mon1 <= 16'd0;
        bus(1'b1, alarm_regs_pkg::IDX_M1_AHI, 16'd100);
        bus(1'b1, alarm_regs_pkg::IDX_M1_HYS, 16'd20);
        bus(1'b1, alarm_regs_pkg::IDX_M1_OSEL, 16'h0004);
        bus(1'b1, alarm_regs_pkg::IDX_M1_MODE, 16'h0060);
        bus(1'b1, alarm_regs_pkg::IDX_IRQ_MASK, 16'h0002);
        bus(1'b1, alarm_regs_pkg::IDX_M1_KIND, alarm_regs_pkg::KIND_PHI);
        @(posedge clk) mon1 <= 16'd150;
        settle(3);
        `CHECK_EQ(events, 15'h0004)
        `CHECK_EQ({audible, shutdown, irq}, 3'b111)
        bus(1'b0, alarm_regs_pkg::IDX_ALM_STAT, 16'h0000);
        `CHECK_EQ(rd, 16'h0002)
        @(posedge clk) mon1 <= 16'd90;
        settle(3);
        `CHECK_EQ(events, 15'h0004)
        @(posedge clk) mon1 <= 16'd70;
        settle(3);
        `CHECK_EQ({events, audible, irq}, {15'h0, 2'b01})
        bus(1'b1, alarm_regs_pkg::IDX_IRQ_MASK, 16'h0000);
        settle(0);
        `CHECK_EQ(irq, 1'b0)
        bus(1'b1, alarm_regs_pkg::IDX_IRQ_STAT, 16'h0002);
        bus(1'b0, alarm_regs_pkg::IDX_IRQ_STAT, 16'h0000);
        `CHECK_EQ(rd, 16'h0000)
        bus(1'b1, alarm_regs_pkg::IDX_IRQ_MASK, 16'h0002);
        settle(0);
        `CHECK_EQ(irq, 1'b0)
        // latch plus bits 0 and 3, which must change nothing
        bus(1'b1, alarm_regs_pkg::IDX_M1_MODE, 16'h000B);
        @(posedge clk) mon1 <= 16'd150;
        settle(3);
        `CHECK_EQ({events, audible}, {15'h4, 1'b0})
        @(posedge clk) mon1 <= 16'd0;
        settle(3);
        `CHECK_EQ(events, 15'h0004)
        // acknowledge passes the pin filter before it acts
        @(posedge clk) ack <= 1'b1;
        settle(6);
        `CHECK_EQ(events, 15'h0000)
        @(posedge clk) ack <= 1'b0;
        bus(1'b1, alarm_regs_pkg::IDX_M1_MODE, 16'h0004);
        settle(1);
        `CHECK_EQ(events, 15'h0004)
        @(posedge clk) mon1 <= 16'd150;
        settle(3);
        `CHECK_EQ(events, 15'h0000)
        bus(1'b1, alarm_regs_pkg::IDX_L5_AHI, 16'd50);
        bus(1'b1, alarm_regs_pkg::IDX_L5_ALO, 16'd50);
        bus(1'b1, alarm_regs_pkg::IDX_L5_OSEL, 16'h0001);
        for (int k = 0; k < 7; k++) begin
            for (int s = 0; s < 3; s++) begin
                bus(1'b1, alarm_regs_pkg::IDX_L5_KIND, 16'(k));
                @(posedge clk) proc5 <= 16'(vals[s]);
                settle(3);
                `CHECK_EQ(events[0], alarm_exp(k, vals[s]))
            end
        end
        summarize();
    end
endmodule // test_loop_and_monitor_alarm_regs
